// ==== rtl/nvmcc_defs.svh ====
// Constants of the nonvolatile command controller
// How it works
// - With no write running, controller sleeps along with the system.
// - A running write keeps array, controller and clock awake in every sleep mode.
// - Ready interrupt wakes the device from idle sleep only.
// - Every wake-up sets the whole page buffer to ones.
// - Protected register writes without a fresh unlock are accepted but ignored.
// - Three-bit command codes: none, write, erase, erase-write, clear, chip, eeprom, fuse.
// - Page commands pick Flash or EEPROM from the address register.
// - Chip erase clears Flash and EEPROM unless the preserve fuse is set.
// - Fuse write runs only when issued from the debug programming port.
// - With boot lock on, boot reads and fetches return zero.
// - Boot lock is written only from boot code and cleared only by reset.
// - Boot lock takes effect once execution first leaves the boot section.
// - Application write protect is set-only and blocks application writes.
// - Write error reads one after a failed last operation.
// - Busy flags show EEPROM and Flash command execution.
// - Ready interrupt is a level: enable and flag both set.
// - Ready flag clears on written one only during an EEPROM page operation; zero leaves it.
// - Enabled ready interrupt requests at once and keeps requesting.
// - Sixteen-bit fuse data: low byte at 0x06, high byte one above.
// - Sixteen-bit address register at 0x08 holds last updated location.
// - Buffer stores AND into contents; buffer resets to ones after ops and clear.
// - CPU stalls during Flash operations, EEPROM erase, fuse write and buffer clear; runs during EEPROM page operations.
`ifndef NVMCC_DEFS_SVH
`define NVMCC_DEFS_SVH
`define NVMCC_OFS_CMD 4'h0
`define NVMCC_OFS_PROT 4'h1
`define NVMCC_OFS_STATE 4'h2
`define NVMCC_OFS_IEN 4'h3
`define NVMCC_OFS_IFLAG 4'h4
`define NVMCC_OFS_DATA_LO 4'h6
`define NVMCC_OFS_DATA_HI 4'h7
`define NVMCC_OFS_ADDR_LO 4'h8
`define NVMCC_OFS_ADDR_HI 4'h9
`define NVMCC_BIT_APP_WP 0
`define NVMCC_BIT_BOOT_LOCK 1
`define NVMCC_BIT_FLASH_BUSY_FLAG 0
`define NVMCC_BIT_EEPROM_BUSY_FLAG 1
`define NVMCC_BIT_WERR 2
`define NVMCC_BIT_READY 0
`define NVMCC_UNLOCK_WINDOW 3'h4
`define NVMCC_CLEAR_CYCLES 4'h7
`define NVMCC_BYTE_ZERO 8'h00
`define NVMCC_WORD_ZERO 16'h0000
`define NVMCC_BYTE_ONES 8'hFF
`endif

// ==== rtl/nvmcc_pkg.sv ====
// Types of the nonvolatile command controller
package nvmcc_pkg;
  typedef enum logic [2:0] {
    NVMCC_CMD_NONE = 3'h0,
    NVMCC_CMD_WRITE_PAGE = 3'h1,
    NVMCC_CMD_ERASE_PAGE = 3'h2,
    NVMCC_CMD_ERASE_WRITE_PAGE = 3'h3,
    NVMCC_CMD_BUFFER_CLEAR = 3'h4,
    NVMCC_CMD_FULL_ERASE = 3'h5,
    NVMCC_CMD_EEPROM_ERASE = 3'h6,
    NVMCC_CMD_FUSE_PROGRAM = 3'h7
  } nvmcc_cmd_type;
  typedef enum logic [3:0] {
    NVMCC_ST_IDLE = 4'b0001,
    NVMCC_ST_FLASH = 4'b0010,
    NVMCC_ST_EEPROM = 4'b0100,
    NVMCC_ST_SLEEP = 4'b1000
  } nvmcc_state_type;
endpackage : nvmcc_pkg

// ==== rtl/nvmcc_buf_if.sv ====
// Page buffer port between controller and buffer
`timescale 1ns/10ps
interface nvmcc_buf_if #(parameter int AW = 6);
  logic store;
  logic [AW-1:0] store_idx;
  logic [7:0] store_data;
  logic clear;
  logic [AW-1:0] rd_idx;
  logic [7:0] rd_data;
  modport ctrl(output store, output store_idx, output store_data, output clear, output rd_idx, input rd_data);
  modport mem(input store, input store_idx, input store_data, input clear, input rd_idx, output rd_data);
endinterface : nvmcc_buf_if

// ==== rtl/nvmcc_page_buf.sv ====
// Shared page buffer memory with AND stores and registered read
`timescale 1ns/10ps
`include "nvmcc_defs.svh"
module nvmcc_page_buf import nvmcc_pkg::*; #(
  parameter int AW = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  nvmcc_buf_if.mem bus
);
  logic [7:0] mem_q [0:(1<<AW)-1];
  logic [7:0] rd_q;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < (1<<AW); i++) mem_q[i] <= `NVMCC_BYTE_ONES;
    end else if (bus.clear) begin
      for (int i = 0; i < (1<<AW); i++) mem_q[i] <= `NVMCC_BYTE_ONES;
    end else if (bus.store) begin
      mem_q[bus.store_idx] <= mem_q[bus.store_idx] & bus.store_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) rd_q <= `NVMCC_BYTE_ONES;
    else rd_q <= mem_q[bus.rd_idx];
  end

  assign bus.rd_data = rd_q;
endmodule : nvmcc_page_buf

// ==== rtl/nvmcc_ctrl.sv ====
// Command, protection, status and sleep logic of the nonvolatile controller
`timescale 1ns/10ps
`include "nvmcc_defs.svh"
module nvmcc_ctrl import nvmcc_pkg::*; #(
  parameter int BUF_AW = 6,
  parameter logic [15:0] EEPROM_BASE = 16'h1400,
  parameter logic [15:0] EEPROM_TOP = 16'h14FF,
  parameter logic [15:0] FLASH_BASE = 16'h8000,
  parameter logic [15:0] APP_BASE = 16'h8400,
  parameter logic [15:0] BOOT_END = 16'h83FF
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_from_debug,
  output logic [7:0] o_reg_rdata,
  // Unlock and execution context
  input wire logic i_self_program_key,
  input wire logic i_instr_retire,
  input wire logic i_exec_in_boot,
  // Array access path from CPU
  input wire logic i_mem_wr,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  input wire logic i_mem_rd,
  input wire logic i_mem_fetch,
  input wire logic [15:0] i_array_rdata,
  output logic [15:0] o_mem_rdata,
  output logic o_cpu_stall,
  // Array engine
  input wire logic i_eeprom_preserve_fuse,
  input wire logic i_array_done,
  output logic o_op_start,
  output nvmcc_cmd_type o_op_cmd,
  output logic o_op_flash,
  output logic o_op_eeprom,
  output logic [15:0] o_op_addr,
  output logic [15:0] o_op_data,
  // Page buffer read for engine
  input wire logic [BUF_AW-1:0] i_buf_rd_idx,
  output logic [7:0] o_buf_rd_data,
  // Sleep
  input wire logic i_sleep_req,
  input wire logic i_sleep_idle,
  input wire logic i_wake,
  output logic o_ctrl_asleep,
  output logic o_keep_clock,
  output logic o_wake_req,
  // Interrupt
  output logic o_eeprom_ready_irq
);
  nvmcc_buf_if #(.AW(BUF_AW)) buf_port ();
  nvmcc_page_buf #(.AW(BUF_AW)) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .bus(buf_port)
  );

  nvmcc_state_type state_q;
  logic [2:0] cmd_q;
  logic [2:0] unlock_cnt_q;
  logic boot_section_lock_q, lock_active_q, app_write_protect_q;
  logic write_error_flag_q, ready_en_q, eeprom_ready_irq_q;
  logic [15:0] data_q, addr_q;
  logic buf_used_q, buf_eeprom_q;
  logic [3:0] clr_cnt_q;
  logic was_asleep_q;
  logic [15:0] mem_rdata_q;

  logic wr_cmd, cmd_go, unlocked, tgt_eeprom, tgt_app, prot_fail, mix_fail, busy;
  logic mem_store, boot_hit, wake_now, buf_clear_cmd;
  nvmcc_cmd_type cmd_in;

  assign cmd_in = nvmcc_cmd_type'(i_reg_wdata[2:0]);
  assign unlocked = (unlock_cnt_q != 3'h0);
  assign wr_cmd = i_reg_wr && (i_reg_addr == `NVMCC_OFS_CMD);
  assign busy = (state_q == NVMCC_ST_FLASH) || (state_q == NVMCC_ST_EEPROM) || (clr_cnt_q != 4'h0);
  assign cmd_go = wr_cmd && unlocked && !busy && (cmd_in != NVMCC_CMD_NONE);
  assign tgt_eeprom = (addr_q >= EEPROM_BASE) && (addr_q <= EEPROM_TOP);
  assign tgt_app = (addr_q >= APP_BASE);
  assign boot_hit = (i_mem_addr >= FLASH_BASE) && (i_mem_addr <= BOOT_END);
  assign mem_store = i_mem_wr && !busy;
  assign mix_fail = buf_used_q && (buf_eeprom_q != tgt_eeprom);
  assign wake_now = (state_q == NVMCC_ST_SLEEP) && i_wake;
  assign buf_clear_cmd = cmd_go && (cmd_in == NVMCC_CMD_BUFFER_CLEAR);

  // Protected area test for the page commands and the fuse write
  always_comb begin
    prot_fail = 1'b0;
    if (cmd_in == NVMCC_CMD_WRITE_PAGE || cmd_in == NVMCC_CMD_ERASE_PAGE || cmd_in == NVMCC_CMD_ERASE_WRITE_PAGE) begin
      if (!tgt_eeprom && tgt_app && app_write_protect_q) prot_fail = 1'b1;
      if (mix_fail && cmd_in != NVMCC_CMD_ERASE_PAGE) prot_fail = 1'b1;
    end
    if (cmd_in == NVMCC_CMD_FUSE_PROGRAM && !i_reg_from_debug) prot_fail = 1'b1;
  end

  // Unlock window after the key
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) unlock_cnt_q <= 3'h0;
    else if (i_self_program_key) unlock_cnt_q <= `NVMCC_UNLOCK_WINDOW;
    else if (wr_cmd) unlock_cnt_q <= 3'h0;
    else if (unlocked && i_instr_retire) unlock_cnt_q <= unlock_cnt_q - 3'h1;
  end

  // Command register and operation launch
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_q <= 3'h0;
      o_op_start <= 1'b0;
      o_op_cmd <= NVMCC_CMD_NONE;
      o_op_flash <= 1'b0;
      o_op_eeprom <= 1'b0;
      o_op_addr <= `NVMCC_WORD_ZERO;
      o_op_data <= `NVMCC_WORD_ZERO;
      write_error_flag_q <= 1'b0;
    end else begin
      o_op_start <= 1'b0;
      if (cmd_go) begin
        cmd_q <= i_reg_wdata[2:0];
        write_error_flag_q <= prot_fail;
        if (!prot_fail && cmd_in != NVMCC_CMD_BUFFER_CLEAR) begin
          o_op_start <= 1'b1;
          o_op_cmd <= cmd_in;
          o_op_addr <= addr_q;
          o_op_data <= data_q;
          case (cmd_in)
            NVMCC_CMD_FULL_ERASE: begin
              o_op_flash <= 1'b1;
              o_op_eeprom <= !i_eeprom_preserve_fuse;
            end
            NVMCC_CMD_EEPROM_ERASE: begin
              o_op_flash <= 1'b0;
              o_op_eeprom <= 1'b1;
            end
            NVMCC_CMD_FUSE_PROGRAM: begin
              o_op_flash <= 1'b0;
              o_op_eeprom <= 1'b0;
            end
            default: begin
              o_op_flash <= !tgt_eeprom;
              o_op_eeprom <= tgt_eeprom;
            end
          endcase
        end
      end else if (state_q == NVMCC_ST_IDLE && !busy) begin
        cmd_q <= 3'h0;
      end
    end
  end

  // Operation state
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) state_q <= NVMCC_ST_IDLE;
    else begin
      case (state_q)
        NVMCC_ST_IDLE: begin
          if (o_op_start && (o_op_flash || o_op_cmd == NVMCC_CMD_EEPROM_ERASE || o_op_cmd == NVMCC_CMD_FUSE_PROGRAM))
            state_q <= NVMCC_ST_FLASH;
          else if (o_op_start) state_q <= NVMCC_ST_EEPROM;
          else if (i_sleep_req && !busy) state_q <= NVMCC_ST_SLEEP;
        end
        NVMCC_ST_FLASH: if (i_array_done) state_q <= NVMCC_ST_IDLE;
        NVMCC_ST_EEPROM: if (i_array_done) state_q <= NVMCC_ST_IDLE;
        NVMCC_ST_SLEEP: if (i_wake) state_q <= NVMCC_ST_IDLE;
        default: state_q <= NVMCC_ST_IDLE;
      endcase
    end
  end

  // Page buffer clear timer for the clear command
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) clr_cnt_q <= 4'h0;
    else if (buf_clear_cmd && !prot_fail) clr_cnt_q <= `NVMCC_CLEAR_CYCLES;
    else if (clr_cnt_q != 4'h0) clr_cnt_q <= clr_cnt_q - 4'h1;
  end

  // Which section the buffer holds
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      buf_used_q <= 1'b0;
      buf_eeprom_q <= 1'b0;
    end else if (buf_port.clear) begin
      buf_used_q <= 1'b0;
    end else if (mem_store && !buf_used_q) begin
      buf_used_q <= 1'b1;
      buf_eeprom_q <= (i_mem_addr >= EEPROM_BASE) && (i_mem_addr <= EEPROM_TOP);
    end
  end

  always_comb begin
    buf_port.store = mem_store;
    buf_port.store_idx = i_mem_addr[BUF_AW-1:0];
    buf_port.store_data = i_mem_wdata;
    buf_port.clear = (buf_clear_cmd && !prot_fail) || wake_now
      || ((state_q == NVMCC_ST_FLASH || state_q == NVMCC_ST_EEPROM) && i_array_done);
    buf_port.rd_idx = i_buf_rd_idx;
  end
  assign o_buf_rd_data = buf_port.rd_data;

  // Protection bits
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      boot_section_lock_q <= 1'b0;
      app_write_protect_q <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == `NVMCC_OFS_PROT) begin
      if (i_reg_wdata[`NVMCC_BIT_BOOT_LOCK] && i_exec_in_boot) boot_section_lock_q <= 1'b1;
      if (i_reg_wdata[`NVMCC_BIT_APP_WP]) app_write_protect_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) lock_active_q <= 1'b0;
    else if (boot_section_lock_q && !i_exec_in_boot) lock_active_q <= 1'b1;
  end

  // Array reads with boot masking
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) mem_rdata_q <= `NVMCC_WORD_ZERO;
    else if (i_mem_rd || i_mem_fetch) begin
      if (lock_active_q && boot_hit) mem_rdata_q <= `NVMCC_WORD_ZERO;
      else mem_rdata_q <= i_array_rdata;
    end
  end
  assign o_mem_rdata = mem_rdata_q;

  // Data and address registers
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_q <= `NVMCC_WORD_ZERO;
      addr_q <= `NVMCC_WORD_ZERO;
    end else begin
      if (i_reg_wr && i_reg_addr == `NVMCC_OFS_DATA_LO) data_q[7:0] <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == `NVMCC_OFS_DATA_HI) data_q[15:8] <= i_reg_wdata;
      if (mem_store) addr_q <= i_mem_addr;
      else if (i_reg_wr && i_reg_addr == `NVMCC_OFS_ADDR_LO) addr_q[7:0] <= i_reg_wdata;
      else if (i_reg_wr && i_reg_addr == `NVMCC_OFS_ADDR_HI) addr_q[15:8] <= i_reg_wdata;
    end
  end

  // Ready interrupt
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ready_en_q <= 1'b0;
      eeprom_ready_irq_q <= 1'b0;
    end else begin
      if (i_reg_wr && i_reg_addr == `NVMCC_OFS_IEN) ready_en_q <= i_reg_wdata[`NVMCC_BIT_READY];
      if (state_q != NVMCC_ST_EEPROM || i_array_done) eeprom_ready_irq_q <= 1'b1;
      else if (i_reg_wr && i_reg_addr == `NVMCC_OFS_IFLAG && i_reg_wdata[`NVMCC_BIT_READY])
        eeprom_ready_irq_q <= 1'b0;
    end
  end
  assign o_eeprom_ready_irq = ready_en_q && eeprom_ready_irq_q;
  assign o_wake_req = o_eeprom_ready_irq && i_sleep_idle && (state_q == NVMCC_ST_SLEEP);

  // Sleep and stall
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) was_asleep_q <= 1'b0;
    else was_asleep_q <= (state_q == NVMCC_ST_SLEEP);
  end
  assign o_ctrl_asleep = (state_q == NVMCC_ST_SLEEP) && was_asleep_q;
  assign o_keep_clock = (state_q == NVMCC_ST_FLASH) || (state_q == NVMCC_ST_EEPROM);
  assign o_cpu_stall = (state_q == NVMCC_ST_FLASH) || (clr_cnt_q != 4'h0)
    || (o_op_start && o_op_flash);

  // Register read
  always_comb begin
    o_reg_rdata = `NVMCC_BYTE_ZERO;
    if (i_reg_rd && i_reg_addr == `NVMCC_OFS_CMD) o_reg_rdata = {5'h00, cmd_q};
    else if (i_reg_rd && i_reg_addr == `NVMCC_OFS_PROT)
      o_reg_rdata = {6'h00, boot_section_lock_q, app_write_protect_q};
    else if (i_reg_rd && i_reg_addr == `NVMCC_OFS_STATE)
      o_reg_rdata = {5'h00, write_error_flag_q, state_q == NVMCC_ST_EEPROM,
                     state_q == NVMCC_ST_FLASH};
    else if (i_reg_rd && i_reg_addr == `NVMCC_OFS_IEN) o_reg_rdata = {7'h00, ready_en_q};
    else if (i_reg_rd && i_reg_addr == `NVMCC_OFS_IFLAG) o_reg_rdata = {7'h00, eeprom_ready_irq_q};
    else if (i_reg_rd && i_reg_addr == `NVMCC_OFS_DATA_LO) o_reg_rdata = data_q[7:0];
    else if (i_reg_rd && i_reg_addr == `NVMCC_OFS_DATA_HI) o_reg_rdata = data_q[15:8];
    else if (i_reg_rd && i_reg_addr == `NVMCC_OFS_ADDR_LO) o_reg_rdata = addr_q[7:0];
    else if (i_reg_rd && i_reg_addr == `NVMCC_OFS_ADDR_HI) o_reg_rdata = addr_q[15:8];
  end
endmodule : nvmcc_ctrl

// ==== testbench/nvmcc_array_model.sv ====
// Array engine model that ends each started operation after a set latency
`timescale 1ns/10ps
module nvmcc_array_model (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [3:0] i_lat,
  input wire logic [15:0] i_addr,
  output logic o_done,
  output logic [15:0] o_rdata
);
  logic [3:0] cnt_q;
  // Data pattern derived from address so stale values cannot match
  assign o_rdata = ~i_addr;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= 4'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt_q == 4'h1);
      if (i_start) cnt_q <= i_lat;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : nvmcc_array_model

// ==== testbench/nvmcc_ctrl_properties.sv ====
// Port-level assertions of the nonvolatile command controller
`timescale 1ns/10ps
module nvmcc_ctrl_chk import nvmcc_pkg::*; #(
  parameter logic [15:0] EEPROM_BASE = 16'h1400,
  parameter logic [15:0] EEPROM_TOP = 16'h14FF
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_from_debug,
  input wire logic i_eeprom_preserve_fuse,
  input wire logic i_sleep_req,
  input wire logic i_sleep_idle,
  input wire logic o_op_start,
  input wire nvmcc_cmd_type o_op_cmd,
  input wire logic o_op_flash,
  input wire logic o_op_eeprom,
  input wire logic [15:0] o_op_addr,
  input wire logic o_cpu_stall,
  input wire logic o_ctrl_asleep,
  input wire logic o_wake_req,
  input wire logic o_eeprom_ready_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic pg;
  // Page commands only
  assign pg = o_op_start && o_op_cmd != NVMCC_CMD_NONE && o_op_cmd <= NVMCC_CMD_ERASE_WRITE_PAGE;
  a_start_needs_write: assert property (o_op_start |-> $past(i_reg_wr) && $past(i_reg_addr) == 4'h0)
    else $error("operation started without a command write");
  a_start_cmd_code: assert property (o_op_start |-> o_op_cmd != NVMCC_CMD_NONE)
    else $error("operation started with no command");
  a_fuse_from_debug: assert property (o_op_start && o_op_cmd == NVMCC_CMD_FUSE_PROGRAM |-> $past(i_reg_from_debug))
    else $error("fuse write started from the cpu");
  a_page_target_sel: assert property (pg |-> o_op_flash == !o_op_eeprom &&
      o_op_eeprom == (o_op_addr >= EEPROM_BASE && o_op_addr <= EEPROM_TOP))
    else $error("page command targets wrong memory");
  a_chip_keeps_eeprom: assert property (o_op_start && o_op_cmd == NVMCC_CMD_FULL_ERASE
      |-> o_op_flash && o_op_eeprom == !i_eeprom_preserve_fuse)
    else $error("chip erase target wrong");
  a_flash_stalls_cpu: assert property (pg && o_op_flash |-> ##[0:1] o_cpu_stall)
    else $error("cpu not stalled by flash operation");
  a_eeprom_runs_cpu: assert property (pg && o_op_eeprom |=> !o_cpu_stall [*2])
    else $error("cpu stalled by eeprom operation");
  a_sleep_follows: assert property (o_ctrl_asleep |-> i_sleep_req)
    else $error("controller asleep without system sleep");
  a_wake_idle_only: assert property (o_wake_req |-> i_sleep_idle && o_eeprom_ready_irq)
    else $error("wake request outside idle sleep");
endmodule : nvmcc_ctrl_chk
bind nvmcc_ctrl nvmcc_ctrl_chk #(.EEPROM_BASE(EEPROM_BASE), .EEPROM_TOP(EEPROM_TOP)) u_chk (.i_clk_sys(i_clk_sys),
  .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_from_debug(i_reg_from_debug),
  .i_eeprom_preserve_fuse(i_eeprom_preserve_fuse), .i_sleep_req(i_sleep_req), .i_sleep_idle(i_sleep_idle),
  .o_op_start(o_op_start), .o_op_cmd(o_op_cmd), .o_op_flash(o_op_flash), .o_op_eeprom(o_op_eeprom),
  .o_op_addr(o_op_addr), .o_cpu_stall(o_cpu_stall), .o_ctrl_asleep(o_ctrl_asleep), .o_wake_req(o_wake_req),
  .o_eeprom_ready_irq(o_eeprom_ready_irq));

// ==== testbench/tb_nvm_command_controller.sv ====
// Self-checking bench of the nonvolatile command controller
`timescale 1ns/10ps
module tb_nvm_command_controller;
  import nvmcc_pkg::*;
  logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_reg_from_debug = 1'b0;
  logic i_self_program_key = 1'b0, i_instr_retire = 1'b0, i_exec_in_boot = 1'b0, i_mem_wr = 1'b0;
  logic i_mem_rd = 1'b0, i_eeprom_preserve_fuse = 1'b0, i_sleep_req = 1'b0, i_sleep_idle = 1'b0, i_wake = 1'b0;
  logic i_mem_fetch = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00, i_mem_wdata = 8'h00, o_reg_rdata, o_buf_rd_data;
  logic [15:0] i_mem_addr = 16'h0000, i_array_rdata, o_mem_rdata, o_op_addr, o_op_data;
  logic [5:0] i_buf_rd_idx = 6'h00;
  logic i_array_done, o_cpu_stall, o_op_start, o_op_flash, o_op_eeprom, o_ctrl_asleep, o_keep_clock;
  logic o_wake_req, o_eeprom_ready_irq;
  nvmcc_cmd_type o_op_cmd;
  int err_total = 0, n_checks = 0, n_start = 0, c;
  always #50 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) if (o_op_start === 1'b1) n_start++;
  nvmcc_ctrl DUT (.i_clk_sys, .i_reset_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_reg_from_debug,
    .o_reg_rdata, .i_self_program_key, .i_instr_retire, .i_exec_in_boot, .i_mem_wr, .i_mem_addr, .i_mem_wdata,
    .i_mem_rd, .i_mem_fetch, .i_array_rdata, .o_mem_rdata, .o_cpu_stall, .i_eeprom_preserve_fuse,
    .i_array_done, .o_op_start, .o_op_cmd, .o_op_flash, .o_op_eeprom, .o_op_addr, .o_op_data, .i_buf_rd_idx,
    .o_buf_rd_data, .i_sleep_req, .i_sleep_idle, .i_wake, .o_ctrl_asleep, .o_keep_clock, .o_wake_req,
    .o_eeprom_ready_irq);
  nvmcc_array_model u_arr (.i_clk_sys, .i_reset_n, .i_start(o_op_start), .i_lat(4'h6), .i_addr(i_mem_addr),
    .o_done(i_array_done), .o_rdata(i_array_rdata));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(negedge i_clk_sys);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    #10 check("register", {8'h00, o_reg_rdata}, {8'h00, exp});
    @(negedge i_clk_sys);
    i_reg_rd = 1'b0;
  endtask : rd
  task automatic st(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_mem_addr = a;
    i_mem_wdata = d;
    i_mem_wr = 1'b1;
    @(negedge i_clk_sys);
    i_mem_wr = 1'b0;
  endtask : st
  task automatic buf_is(input logic [5:0] idx, input logic [7:0] exp);
    @(negedge i_clk_sys);
    i_buf_rd_idx = idx;
    @(negedge i_clk_sys);
    check("buffer", {8'h00, o_buf_rd_data}, {8'h00, exp});
  endtask : buf_is
  // Key, then n retired instructions, then the command write
  task automatic cmd(input logic [2:0] code, input int nret);
    @(negedge i_clk_sys);
    i_self_program_key = 1'b1;
    @(negedge i_clk_sys);
    i_self_program_key = 1'b0;
    i_instr_retire = (nret > 0);
    repeat (nret) @(negedge i_clk_sys);
    i_instr_retire = 1'b0;
    wr(4'h0, {5'h00, code});
  endtask : cmd
  task automatic wait_idle;
    int k;
    repeat (3) @(negedge i_clk_sys);
    i_reg_addr = 4'h2;
    i_reg_rd = 1'b1;
    #1;
    for (k = 0; k < 60 && o_reg_rdata[1:0] !== 2'b00; k++) @(negedge i_clk_sys);
    i_reg_rd = 1'b0;
    if (k == 60) begin
      err_total++;
      tally_and_finish;
    end
  endtask : wait_idle
  initial begin
    repeat (6) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    rd(4'h2, 8'h00);
    rd(4'h4, 8'h01);
    rd(4'h5, 8'h00);
    for (int i = 6; i < 10; i++) wr(i[3:0], 8'h30 + i[7:0]);
    for (int i = 6; i < 10; i++) rd(i[3:0], 8'h30 + i[7:0]);
    wr(4'h0, 8'h01);
    cmd(3'h1, 4);
    repeat (2) @(negedge i_clk_sys);
    check("refused starts", n_start[15:0], 16'h0000);
    $display("test registers and unlock done");
    st(16'h1410, 8'hF0);
    st(16'h1410, 8'h3C);
    buf_is(6'h10, 8'h30);
    rd(4'h8, 8'h10);
    wr(4'h3, 8'h01);
    check("irq enabled", {15'h0, o_eeprom_ready_irq}, 16'h0001);
    cmd(3'h2, 3);
    @(negedge i_clk_sys);
    check("eeprom target", {o_op_eeprom, o_op_addr[14:0]}, 16'h9410);
    rd(4'h2, 8'h02);
    wr(4'h4, 8'h01);
    check("irq busy stall", {14'h0, o_eeprom_ready_irq, o_cpu_stall}, 16'h0000);
    wait_idle;
    buf_is(6'h10, 8'hFF);
    wr(4'h4, 8'h00);
    check("irq after op", {15'h0, o_eeprom_ready_irq}, 16'h0001);
    wr(4'h3, 8'h00);
    check("irq disabled", {15'h0, o_eeprom_ready_irq}, 16'h0000);
    $display("test eeprom page done");
    i_eeprom_preserve_fuse = 1'b1;
    st(16'h8402, 8'h55);
    for (c = 1; c < 7; c++) begin
      if (c != 4) begin
        cmd(c[2:0], 0);
        @(negedge i_clk_sys);
        check("command", {12'h0, o_op_flash, o_op_cmd}, {12'h0, c != 6, c[2:0]});
        if (c == 6) check("eeprom erase", {15'h0, o_op_eeprom}, 16'h0001);
        if (c == 5) check("preserve", {15'h0, o_op_eeprom}, 16'h0000);
        @(negedge i_clk_sys);
        if (c < 4) check("stall", {15'h0, o_cpu_stall}, 16'h0001);
        wait_idle;
      end
    end
    st(16'h8405, 8'h0F);
    cmd(3'h4, 0);
    repeat (9) @(negedge i_clk_sys);
    buf_is(6'h05, 8'hFF);
    $display("test command codes done");
    wr(4'h1, 8'h01);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h01);
    c = n_start;
    cmd(3'h1, 0);
    rd(4'h2, 8'h04);
    cmd(3'h7, 0);
    rd(4'h2, 8'h04);
    check("refused starts", n_start[15:0], c[15:0]);
    i_reg_from_debug = 1'b1;
    cmd(3'h7, 0);
    @(negedge i_clk_sys);
    check("fuse data", o_op_data, 16'h3736);
    i_reg_from_debug = 1'b0;
    wait_idle;
    $display("test protection and fuse done");
    i_exec_in_boot = 1'b1;
    wr(4'h1, 8'h03);
    rd(4'h1, 8'h03);
    i_mem_addr = 16'h8010;
    i_mem_rd = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    check("boot read in boot", o_mem_rdata, 16'h7FEF);
    i_exec_in_boot = 1'b0;
    i_mem_rd = 1'b0;
    i_mem_fetch = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    check("boot fetch locked", o_mem_rdata, 16'h0000);
    i_mem_fetch = 1'b0;
    $display("test boot lock done");
    st(16'h1401, 8'h00);
    i_sleep_req = 1'b1;
    i_sleep_idle = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    check("asleep", {15'h0, o_ctrl_asleep}, 16'h0001);
    wr(4'h3, 8'h01);
    check("wake idle", {15'h0, o_wake_req}, 16'h0001);
    i_sleep_idle = 1'b0;
    #1 check("wake deep", {15'h0, o_wake_req}, 16'h0000);
    i_wake = 1'b1;
    @(negedge i_clk_sys);
    i_wake = 1'b0;
    i_sleep_req = 1'b0;
    buf_is(6'h01, 8'hFF);
    cmd(3'h1, 0);
    i_sleep_req = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    check("keep awake", {14'h0, o_keep_clock, o_ctrl_asleep}, 16'h0002);
    wait_idle;
    i_sleep_req = 1'b0;
    $display("test sleep done");
    tally_and_finish;
  end
endmodule : tb_nvm_command_controller
